// ==== include/pfc_consts.svh ====
`ifndef PFC_CONSTS_SVH
`define PFC_CONSTS_SVH
// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define PFC_ADDR_W 12
`define PFC_ADDR_CFG 12'h0400
`define PFC_ADDR_TAP0 12'h0418
`define PFC_ADDR_TAP1 12'h041A
`define PFC_ADDR_TAP2 12'h041C
`define PFC_ADDR_GAIN 12'h0357
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PFC_CFG_RESET 8'h00
`define PFC_COEFF_RESET 16'h0000
`define PFC_GAIN_RESET 8'h00
`define PFC_RDATA_RESET 16'h0000
// ----------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------
`define PFC_SHARE_BIT 6
`define PFC_MERGE_BIT 5
`define PFC_SCW_HI 4
`define PFC_SCW_LO 2
`define PFC_MODE_HI 1
`define PFC_MODE_LO 0
`define PFC_MODE_ENABLE 2'h2
`define PFC_SCW_MAX 3'h6
`define PFC_COEFF_HI 11
`define PFC_COEFF_MSB 11
`define PFC_GAIN_HI 4
`define PFC_SIDE_W 12
`define PFC_CENTER_W 18
`define PFC_NUM_TAPS 9
`define PFC_FIFO_DEPTH 8
`define PFC_SAMPLE_W 12
`endif

// ==== include/pfc_pkg.sv ====
`include "pfc_consts.svh"
package pfc_pkg;
    // Side tap coefficient, signed two's complement
    typedef logic signed [`PFC_SIDE_W-1:0] pfc_coeff_t;
    // First three side taps of one channel
    typedef pfc_coeff_t [2:0] pfc_taps_t;
    // Whole register-file state of the configuration block
    typedef struct packed {
        logic [7:0] cfg;
        logic [15:0] tap0;
        logic [15:0] tap1;
        logic [15:0] tap2;
        logic [7:0] gain;
        logic [15:0] rdata;
        logic rdValid;
    } pfc_state_s;
endpackage

// ==== include/pfc_stream_if.sv ====
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Valid/ready sample stream between the block's own modules
// ----------------------------------------------------------------
interface pfc_stream_if #(parameter int W = 13);
    logic valid; // Producer has a word
    logic ready; // Consumer takes it
    logic [W-1:0] data; // Payload
    modport src(output valid, output data, input ready);
    modport snk(input valid, input data, output ready);
endinterface

// ==== src/pfc_fifo.sv ====
`timescale 1ns/100ps
`include "pfc_consts.svh"
module pfc_fifo #(
    parameter int W = 13,
    parameter int DEPTH = `PFC_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Filling side
    pfc_stream_if.snk push,
    // Draining side
    pfc_stream_if.src pop
);
    import pfc_pkg::*;
    localparam int AW = $clog2(DEPTH);

    // Pointer compare needs a power-of-two depth
    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
            $error("pfc_fifo depth must be a power of two of at least 2");
        end
    endgenerate

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem; // Storage words
        logic [AW:0] wr; // Write pointer with wrap bit
        logic [AW:0] rd; // Read pointer with wrap bit
    } pfc_fifo_s;
    pfc_fifo_s q, next_q;
    logic full, empty;

    // Wrap bit tells full from empty when the indices match
    assign full = (q.wr[AW] != q.rd[AW]) && (q.wr[AW-1:0] == q.rd[AW-1:0]);
    assign empty = (q.wr == q.rd);
    assign push.ready = !full;
    assign pop.valid = !empty;
    assign pop.data = q.mem[q.rd[AW-1:0]];

    // Pointer and storage update
    always_comb begin
        next_q = q;
        if (push.valid && !full) begin
            next_q.mem[q.wr[AW-1:0]] = push.data;
            next_q.wr = q.wr + 1'b1;
        end
        if (pop.ready && !empty) begin
            next_q.rd = q.rd + 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_no_overfill: assert property (@(posedge clk) disable iff (rst)
        full |=> !(q.wr == q.rd)) else $error("fifo wrapped to empty from full");
endmodule

// ==== src/pfc_config.sv ====
`timescale 1ns/100ps
`include "pfc_consts.svh"
// What this block does
// - Share bit gives channel B channel A coefficients
// - Merge bit makes one single sample stream
// - Side weight field sets side LSB weight
// - Mode 0 disables, mode 2 enables filter
// - Side coefficient signed in bits 11:0
// - Three registers supply taps one to three
// - Readback shows coefficient MSB as zero
// - Configuration register resets to zero
// - Fine gain trim held in bits 4:0
// - Nine taps, centre tap eighteen bits wide
module pfc_config #(
    parameter int SAMPLE_W = `PFC_SAMPLE_W,
    parameter int FIFO_DEPTH = `PFC_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [`PFC_ADDR_W-1:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [15:0] regRdata,
    output logic regRdValid,
    // Channel B own coefficient set, held elsewhere
    input wire pfc_pkg::pfc_taps_t bOwnCoeff,
    // Converter sample stream in
    input wire logic inValid,
    output logic inReady,
    input wire logic [SAMPLE_W-1:0] inSample,
    input wire logic inChannel,
    // Sample stream towards the serial link
    output logic outValid,
    input wire logic outReady,
    output logic [SAMPLE_W-1:0] outSample,
    output logic outChannel,
    // Filter setup towards the arithmetic
    output logic filterEnable,
    output logic mergeActive,
    output logic [2:0] sideWeight,
    output pfc_pkg::pfc_taps_t coeffA,
    output pfc_pkg::pfc_taps_t coeffB,
    output logic [4:0] gainTrim
);
    import pfc_pkg::*;
    localparam int PW = SAMPLE_W + 1;
    localparam int NUM_TAPS = `PFC_NUM_TAPS;
    localparam int CENTER_W = `PFC_CENTER_W;

    // Sample width must fit the arithmetic; taps fixed at nine
    generate
        // Nine taps with an eighteen-bit centre are what the arithmetic expects
        if (SAMPLE_W < 1 || SAMPLE_W > 16 || NUM_TAPS != 9 || CENTER_W != 18) begin : g_bad
            $error("pfc_config parameters out of range");
        end
    endgenerate

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    pfc_state_s q, next_q;
    logic hitCfg, hitTap0, hitTap1, hitTap2, hitGain, hitCoeff;
    logic [1:0] mode;

    // Address decode
    assign hitCfg = (regAddr == `PFC_ADDR_CFG);
    assign hitTap0 = (regAddr == `PFC_ADDR_TAP0);
    assign hitTap1 = (regAddr == `PFC_ADDR_TAP1);
    assign hitTap2 = (regAddr == `PFC_ADDR_TAP2);
    assign hitGain = (regAddr == `PFC_ADDR_GAIN);
    assign hitCoeff = hitTap0 || hitTap1 || hitTap2;

    // Fill next state from writes and reads
    always_comb begin
        next_q = q;
        next_q.rdValid = regRead;
        // No change to registers is refused here; the link must be off
        // while software rewrites them, so mid-frame tap changes are
        // the writer's hazard
        if (regWrite) begin
            if (hitCfg) begin
                next_q.cfg = regWdata[7:0];
            end
            // All sixteen bits stored; reserved top nibble resets to zero
            if (hitTap0) begin
                next_q.tap0 = regWdata;
            end
            if (hitTap1) begin
                next_q.tap1 = regWdata;
            end
            if (hitTap2) begin
                next_q.tap2 = regWdata;
            end
            if (hitGain) begin
                next_q.gain = regWdata[7:0];
            end
        end
        if (regRead) begin
            // Unmapped addresses read as zero
            next_q.rdata = `PFC_RDATA_RESET;
            if (hitCfg) begin
                next_q.rdata = {8'h00, q.cfg};
            end
            if (hitTap0) begin
                next_q.rdata = q.tap0;
            end
            if (hitTap1) begin
                next_q.rdata = q.tap1;
            end
            if (hitTap2) begin
                next_q.rdata = q.tap2;
            end
            if (hitGain) begin
                next_q.rdata = {8'h00, q.gain};
            end
            // Known readback defect kept on purpose: the filter still
            // uses the stored MSB, only the read path loses it
            if (hitCoeff) begin
                next_q.rdata[`PFC_COEFF_MSB] = 1'b0;
            end
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            q.cfg <= `PFC_CFG_RESET;
            q.tap0 <= `PFC_COEFF_RESET;
            q.tap1 <= `PFC_COEFF_RESET;
            q.tap2 <= `PFC_COEFF_RESET;
            q.gain <= `PFC_GAIN_RESET;
            q.rdata <= `PFC_RDATA_RESET;
            q.rdValid <= 1'b0;
        end else begin
            q <= next_q;
        end
    end

    assign regRdata = q.rdata;
    assign regRdValid = q.rdValid;

    // ----------------------------------------------------------------
    // Configuration decode
    // ----------------------------------------------------------------
    assign mode = q.cfg[`PFC_MODE_HI:`PFC_MODE_LO];
    // Reserved codes 1 and 3 leave the filter off
    assign filterEnable = (mode == `PFC_MODE_ENABLE);
    // Software is trusted to set this for single-channel operation
    assign mergeActive = q.cfg[`PFC_MERGE_BIT];
    // Exponent offset; weight is two to (field minus sixteen).
    // Code 7 is outside the legal range and is clamped to 6
    assign sideWeight = (q.cfg[`PFC_SCW_HI:`PFC_SCW_LO] > `PFC_SCW_MAX) ?
        `PFC_SCW_MAX : q.cfg[`PFC_SCW_HI:`PFC_SCW_LO];
    // Taps one to three for channel A or the merged filter
    assign coeffA[0] = q.tap0[`PFC_COEFF_HI:0];
    assign coeffA[1] = q.tap1[`PFC_COEFF_HI:0];
    assign coeffA[2] = q.tap2[`PFC_COEFF_HI:0];
    // Channel B follows channel A only while sharing
    assign coeffB = q.cfg[`PFC_SHARE_BIT] ? coeffA : bOwnCoeff;
    assign gainTrim = q.gain[`PFC_GAIN_HI:0];

    // ----------------------------------------------------------------
    // Sample path
    // ----------------------------------------------------------------
    pfc_stream_if #(.W(PW)) inS();
    pfc_stream_if #(.W(PW)) outS();

    // Input side; ready reaches the converter for back-pressure
    assign inS.valid = inValid;
    assign inS.data = {inChannel, inSample};
    assign inReady = inS.ready;
    // Output side; samples leave untouched so a disabled filter adds
    // no scaling, the arithmetic downstream is gated by filterEnable
    assign outValid = outS.valid;
    assign outS.ready = outReady;
    assign outSample = outS.data[SAMPLE_W-1:0];
    // Merged stream carries one channel tag only
    assign outChannel = mergeActive ? 1'b0 : outS.data[SAMPLE_W];

    // Rate-smoothing buffer between converter and link
    pfc_fifo #(.W(PW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst(rst),
        .push(inS),
        .pop(outS)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // A write of mode 2 to the configuration register
    sequence s_cfg_enable;
        regWrite && hitCfg && (regWdata[1:0] == `PFC_MODE_ENABLE);
    endsequence
    // A write of a reserved or disabling mode
    sequence s_cfg_disable;
        regWrite && hitCfg && (regWdata[1:0] != `PFC_MODE_ENABLE);
    endsequence
    // A read of any coefficient register
    sequence s_coeff_read;
        regRead && hitCoeff;
    endsequence

    a_cfg_reset: assert property (
        $past(rst) |-> (q.cfg == `PFC_CFG_RESET) && !filterEnable)
        else $error("config not zero after reset");
    a_mode_enable: assert property (s_cfg_enable |=> filterEnable)
        else $error("mode 2 did not enable filter");
    a_mode_disable: assert property (s_cfg_disable |=> !filterEnable)
        else $error("filter on with mode other than 2");
    a_share_used: assert property (q.cfg[`PFC_SHARE_BIT] |-> coeffB == coeffA)
        else $error("shared channel B taps differ from A");
    a_own_used: assert property (!q.cfg[`PFC_SHARE_BIT] |-> coeffB == bOwnCoeff)
        else $error("unshared channel B not on own taps");
    // Weight follows the written field; the illegal code lands on the top value
    a_weight_range: assert property (
        regWrite && hitCfg |=> (sideWeight <= `PFC_SCW_MAX) &&
        ((sideWeight == $past(regWdata[`PFC_SCW_HI:`PFC_SCW_LO])) ||
        (($past(regWdata[`PFC_SCW_HI:`PFC_SCW_LO]) > `PFC_SCW_MAX) &&
        (sideWeight == `PFC_SCW_MAX))))
        else $error("side weight not taken from write");
    a_tap_store: assert property (
        regWrite && hitTap1 |=> ##1 coeffA[1] == $past(regWdata[`PFC_COEFF_HI:0], 2))
        else $error("tap two not stored");
    a_readback_msb: assert property (
        s_coeff_read |=> regRdValid && !regRdata[`PFC_COEFF_MSB])
        else $error("coefficient MSB read as one");
    a_gain_store: assert property (
        regWrite && hitGain |=> gainTrim == $past(regWdata[`PFC_GAIN_HI:0]))
        else $error("gain trim not stored");
    a_merge_tag: assert property (outValid && mergeActive |-> !outChannel)
        else $error("merged stream shows channel B");
endmodule

// ==== verif/pfc_link_model.sv ====
`timescale 1ns/100ps
// ------------------------------------------
// Serial link side of the sample stream
// ------------------------------------------
module pfc_link_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Link control from the bench
    input wire logic linkOn,
    input wire logic slow,
    // Handshake towards the block
    output logic outReady
);
    // Ready moves just after the edge. Slow mode takes every other cycle,
    // so pushes and pops overlap and the FIFO is exercised both ways.
    always_ff @(posedge clk) begin
        if (rst) begin
            outReady <= 1'b0;
        end else begin
            // A stopped link takes nothing; the bench only rewrites setup then
            outReady <= linkOn && (!slow || !outReady);
        end
    end
endmodule

// ==== verif/tb.sv ====
`timescale 1ns/100ps
`include "pfc_consts.svh"
module tb;
    import pfc_pkg::*;
    // ------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------
    logic clk = 1'b0; // 40 MHz system clock
    logic rst = 1'b1; // Synchronous reset
    logic [11:0] regAddr = 12'h000;
    logic [15:0] regWdata = 16'h0000;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [15:0] regRdata;
    logic regRdValid;
    pfc_taps_t bOwnCoeff = '0; // Channel B own taps
    logic inValid = 1'b0;
    logic inReady;
    logic [11:0] inSample = 12'h000;
    logic inChannel = 1'b0;
    logic outValid, outReady, outChannel, filterEnable, mergeActive;
    logic [11:0] outSample;
    logic [2:0] sideWeight;
    logic [4:0] gainTrim;
    pfc_taps_t coeffA, coeffB;
    logic linkOn = 1'b0; // Link running, also the drain gate
    logic slow = 1'b0; // Partner takes every other cycle
    logic merged = 1'b0; // Merge setting the bench has written
    logic [11:0] tap [3]; // Written coefficient values
    logic [15:0] rq [$]; // Expected read data
    logic [12:0] sq [$]; // Expected stream words, tag above sample
    logic [31:0] seed = 32'h0000_536a;
    int n_mismatch = 0;
    int num_checks = 0;
    logic [11:0] addrs [5] = '{`PFC_ADDR_CFG, `PFC_ADDR_TAP0, `PFC_ADDR_TAP1,
        `PFC_ADDR_TAP2, `PFC_ADDR_GAIN};

    // ------------------------------------------
    // Block and its link partner
    // ------------------------------------------
    pfc_config #(.SAMPLE_W(12), .FIFO_DEPTH(8)) uut (.clk, .rst, .regAddr, .regWdata,
        .regWrite, .regRead, .regRdata, .regRdValid, .bOwnCoeff, .inValid, .inReady,
        .inSample, .inChannel, .outValid, .outReady, .outSample, .outChannel,
        .filterEnable, .mergeActive, .sideWeight, .coeffA, .coeffB, .gainTrim);
    pfc_link_model link (.clk, .rst, .linkOn, .slow, .outReady);

    // Clock toggles every half period
    always #12.5 clk = ~clk;

    // Xorshift source, fixed start
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        rnd = seed;
    endfunction

    // Compare and count
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One write strobe; returns just after the taking edge has landed
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
        #1;
    endtask

    // One read strobe; the answer is judged by the watcher
    task automatic rd(input logic [11:0] a, input logic [15:0] e);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        rq.push_back(e);
        @(posedge clk);
        regRead <= 1'b0;
    endtask

    // Offer one sample, held until an edge sees room; call at an edge
    task automatic push(input logic [11:0] s, input logic c);
        int n;
        n = 0;
        inValid <= 1'b1;
        inSample <= s;
        inChannel <= c;
        do begin
            @(posedge clk);
            n++;
        end while (!inReady && n < 100);
        sq.push_back({c & !merged, s});
    endtask

    // Wait until every noted word has left
    task automatic drain();
        int n;
        n = 0;
        while (sq.size() > 0 && n < 300) begin
            @(posedge clk);
            n++;
        end
        @(posedge clk);
        #1;
        chk("fifo empty", 16'h0001, {14'h0, outValid, inReady});
    endtask

    // Watcher: each result takes the oldest note
    always @(posedge clk) begin
        if (!rst && outValid === 1'b1 && outReady === 1'b1) begin
            if (sq.size() == 0)
                chk("stream", 16'hffff, {3'h0, outChannel, outSample});
            else
                chk("stream", {3'h0, sq.pop_front()}, {3'h0, outChannel, outSample});
        end
        if (regRdValid === 1'b1) begin
            if (rq.size() == 0)
                chk("read", 16'hffff, regRdata);
            else
                chk("read", rq.pop_front(), regRdata);
        end
    end

    // Single closing point
    task give_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Watchdog sized well past the expected run of about a hundred and thirty cycles
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        give_verdict();
    end

    // ------------------------------------------
    // Main sequence
    // ------------------------------------------
    initial begin
        logic [15:0] d;
        logic [7:0] c;
        int i;
        int k;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (k = 0; k < 5; k++) rd(addrs[k], 16'h0000);
        chk("setup", 16'h0001, {9'h0, filterEnable, mergeActive, sideWeight, outValid, inReady});
        $display("test reset done");
        // Taps, first one with its top bit set to expose the readback defect
        for (k = 0; k < 3; k++) begin
            d = 16'(rnd());
            d[11] = (k == 0) ? 1'b1 : d[11];
            wr(addrs[k + 1], d);
            tap[k] = d[11:0];
            chk("coeffA", {4'h0, d[11:0]}, {4'h0, coeffA[k]});
            rd(addrs[k + 1], {d[15:12], 1'b0, d[10:0]});
        end
        $display("test taps done");
        // Every mode, weight and share/merge mix
        for (i = 0; i < 8; i++) begin
            d = 16'(rnd());
            c = {d[0], i[0], i[1], i[2:0], i[1:0]};
            wr(addrs[0], {8'h00, c});
            @(posedge clk);
            bOwnCoeff <= {d[3:0], rnd()};
            #1;
            chk("setup", {11'h0, i[1:0] == 2'h2, i[1], (i == 7) ? 3'h6 : i[2:0]},
                {11'h0, filterEnable, mergeActive, sideWeight});
            for (k = 0; k < 3; k++)
                chk("coeffB", {4'h0, i[0] ? tap[k] : bOwnCoeff[k]}, {4'h0, coeffB[k]});
            rd(addrs[0], {8'h00, c});
        end
        $display("test config done");
        // Trim register, then an unmapped place that must change nothing
        d = 16'(rnd());
        wr(addrs[4], d);
        chk("gainTrim", {11'h0, d[4:0]}, {11'h0, gainTrim});
        rd(addrs[4], {8'h00, d[7:0]});
        wr(12'h402, d);
        rd(12'h402, 16'h0000);
        rd(addrs[0], {8'h00, c});
        $display("test gain done");
        // Single-channel stream: fill against a stopped link, then drain
        wr(addrs[0], 16'h0022);
        merged = 1'b1;
        @(posedge clk);
        for (k = 0; k < 8; k++) begin
            d = 16'(rnd());
            push(d[11:0], d[12]);
        end
        inSample <= 12'hfff;
        repeat (3) @(posedge clk);
        chk("inReady", 16'h0000, {15'h0, inReady});
        inValid <= 1'b0;
        linkOn <= 1'b1;
        drain();
        $display("test fill done");
        // Disabled filter, dual stream, slow link while pushing
        @(posedge clk);
        linkOn <= 1'b0;
        wr(addrs[0], 16'h0000);
        merged = 1'b0;
        @(posedge clk);
        linkOn <= 1'b1;
        slow <= 1'b1;
        for (k = 0; k < 12; k++) begin
            d = 16'(rnd());
            push(d[11:0], d[12]);
        end
        inValid <= 1'b0;
        drain();
        chk("reads left", 16'h0000, 16'(rq.size()));
        $display("test stream done");
        give_verdict();
    end
endmodule
